// ---- design/khm_pkg.sv ----
// constants, types and register layout for the keyboard host mailbox
package khm_pkg;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int CORE_CLK_HZ = 12000000;
  localparam int REF_CLK_KHZ = 14318;
  localparam int ALT_DELAY_NS = 500;
  localparam int ALT_PULSE_NS = 1000;
  localparam int ALT_DELAY_CYC = (ALT_DELAY_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int ALT_PULSE_CYC = (ALT_PULSE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int CORE_ACC_STEP = CORE_CLK_HZ / 4000000;
  localparam int CORE_ACC_MOD = SYS_CLK_HZ / 4000000;
  localparam logic [7:0] HOST_DATA_ADDR = 8'h60;
  localparam logic [7:0] HOST_CMD_ADDR = 8'h64;
  localparam logic [7:0] FAST_RESET_ADDR = 8'h92;
  localparam int HOST_ADDR_CD_BIT = 2;
  localparam logic [7:0] FAST_RESET_RST = 8'h24;
  localparam logic [7:0] FAST_RESET_WMASK = 8'h03;
  localparam int FR_A20_BIT = 1;
  localparam int FR_RST_BIT = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] STATUS_USER_MASK = 8'hf4;
  localparam int ST_OUT_FULL_BIT = 0;
  localparam int ST_IN_FULL_BIT = 1;
  localparam int ST_CD_BIT = 3;
  localparam logic [7:0] PORT2_RST = 8'hcc;
  localparam int P2_KBD_CLOCK_BIT = 6;
  localparam int P2_KBD_DATA_BIT = 7;
  localparam int P2_MCLK_BIT = 3;
  localparam int P2_MOUSE_DATA_BIT = 2;
  localparam int ROM_DEPTH = 2048;
  localparam int RAM_DEPTH = 256;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;
  typedef enum logic [1:0] {
    KHM_RUN = 2'b00,
    KHM_SOFT_PD = 2'b01,
    KHM_HARD_PD = 2'b10
  } khm_pwr_t;
endpackage

// ---- design/khm_top.sv ----
// keyboard controller host mailbox, power-down control, pins and fast-reset port
// Operation
// RQ1: keyboard clock/data pins are inverted port2 bits 6/7, open drain, read back.
// RQ2: mouse clock/data pins are inverted port2 bits 3/2, open drain, read back.
// RQ3: soft power-down stops the alu clock, timer and interrupts keep running.
// RQ4: halt enters soft power-down; reset or host write leaves it.
// RQ5: host-write wake calls interrupt routine if input-full interrupt enabled, else continues.
// RQ6: reset wake runs normal reset sequence, fetching from address zero.
// RQ7: stop enters hard power-down, halts clock, disables oscillator; same wakes.
// RQ8: system holds reset long enough for restarted oscillator to settle.
// RQ9: only two controller interrupts: input full and timer overflow.
// RQ10: on-chip 2K program memory and 256 byte data memory.
// RQ11: controller data write loads output buffer, sets output-full, raises keyboard interrupt.
// RQ12: controller data read returns last host byte and clears input-full.
// RQ13: status holds output-full bit0, input-full bit1, command/data bit3, rest user.
// RQ14: status clears on reset, host reads only, controller writes user bits.
// RQ15: host write sets command/data from host address bit 2.
// RQ16: host write sets input-full and interrupt; controller read clears both.
// RQ17: output-full set by controller write, cleared by host read.
// RQ18: core clock is 12 MHz derived from the system clock.
// RQ19: any reset lasts at least 24 reference clock periods; the alternate reset pulse here lasts 20 system clocks (1000 ns).
// RQ20: platform reset drives all four pins low and clears status.
// RQ21: fast-reset port accessible only while its config enable bit is set.
// RQ22: fast-reset register at 92h, default 24h, drives alt reset and gate.
// RQ23: bit 1 write drives alternate gate output to written value.
// RQ24: bit 0 rising write pulses alternate reset low after delay, once.
// RQ25: disabled fast-reset port ignores writes and does not answer reads.
`timescale 1ns/10ps

module khm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
    cnt_r == (AW+1)'(DEPTH) |=> cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo count ran past depth");
endmodule

module khm_top
  import khm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [7:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  output logic HOST_WR_READY,
  output logic [7:0] HOST_RDATA,
  output logic HOST_RACK,
  input wire logic FAST_RESET_GATE_CONFIG,
  output logic ALTERNATE_CPU_RESET_N,
  output logic ALTERNATE_GATE_A20,
  output logic KEYBOARD_INTERRUPT_OUT,
  input wire logic CTL_DATA_WR,
  input wire logic CTL_DATA_RD,
  input wire logic CTL_STATUS_WR,
  input wire logic [7:0] CTL_WDATA,
  output logic [7:0] CTL_DATA_RDATA,
  output logic [7:0] CTL_STATUS,
  input wire logic CTL_KBD_INT_EN,
  input wire logic CTL_IN_FULL_INT_EN,
  input wire logic CTL_TMR_INT_EN,
  input wire logic CTL_TMR_RUN,
  input wire logic CTL_TMR_ACK,
  output logic CTL_INT_IN_FULL,
  output logic CTL_INT_TMR,
  input wire logic CTL_HALT,
  input wire logic CTL_STOP,
  output logic CORE_CLK_EN,
  output logic ALU_CLK_EN,
  output logic OSC_DRV_EN,
  output logic CTL_WAKE_CALL,
  output logic CTL_WAKE_NEXT,
  output logic CTL_FETCH_ZERO,
  input wire logic [10:0] CTL_PC,
  output logic [7:0] CTL_OPCODE,
  input wire logic PGM_LOAD_WE,
  input wire logic [10:0] PGM_LOAD_ADDR,
  input wire logic [7:0] PGM_LOAD_DATA,
  input wire logic [7:0] CTL_RAM_ADDR,
  input wire logic CTL_RAM_WE,
  output logic [7:0] CTL_RAM_RDATA,
  input wire logic CTL_PORT2_WR,
  output logic [7:0] CTL_PORT2,
  output logic PORT1_BIT0,
  output logic PORT1_BIT1,
  output logic TEST_INPUT_ZERO,
  output logic TEST_INPUT_ONE,
  input wire logic KBD_CLOCK_PIN_I,
  output logic KBD_CLOCK_PIN_O,
  output logic KBD_CLOCK_PIN_OE,
  input wire logic KBD_DATA_PIN_I,
  output logic KBD_DATA_PIN_O,
  output logic KBD_DATA_PIN_OE,
  input wire logic MOUSE_CLOCK_PIN_I,
  output logic MOUSE_CLOCK_PIN_O,
  output logic MOUSE_CLOCK_PIN_OE,
  input wire logic MOUSE_DATA_PIN_I,
  output logic MOUSE_DATA_PIN_O,
  output logic MOUSE_DATA_PIN_OE
);
  logic [7:0] rom [ROM_DEPTH];
  logic [7:0] ram [RAM_DEPTH];
  logic [2:0] acc_r;
  logic core_tick;
  khm_pwr_t pwr_r;
  logic [7:0] out_buf_r;
  logic [7:0] in_buf_r;
  logic out_full_r;
  logic in_full_r;
  logic cd_r;
  logic [7:0] user_bits_r;
  logic [7:0] tmr_r;
  logic tmr_flag_r;
  logic [7:0] p2_r;
  logic [7:0] fr_r;
  logic [4:0] alt_cnt_r;
  logic alt_armed_r;
  logic alt_pulse_r;
  logic host_wr_data;
  logic host_fr_hit;
  logic fifo_ready;
  logic fifo_valid;
  logic [8:0] fifo_data;
  logic in_load;
  logic host_out_rd;
  logic host_fr_wr;

  // ticks at 12/20 of the system rate; fraction keeps the average exact
  assign core_tick = (acc_r >= 3'(CORE_ACC_MOD - CORE_ACC_STEP)); // RQ18
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      acc_r <= '0;
    end else if (pwr_r != KHM_HARD_PD) begin
      acc_r <= core_tick ? acc_r - 3'(CORE_ACC_MOD - CORE_ACC_STEP) : acc_r + 3'(CORE_ACC_STEP); // RQ18
    end
  end

  // host path: address decode, writes queue so the host can be stalled
  assign host_wr_data = HOST_WR && (HOST_ADDR == HOST_DATA_ADDR || HOST_ADDR == HOST_CMD_ADDR);
  assign host_fr_hit = (HOST_ADDR == FAST_RESET_ADDR) && FAST_RESET_GATE_CONFIG; // RQ21 RQ25
  assign host_fr_wr = HOST_WR && host_fr_hit;
  assign host_out_rd = HOST_RD && HOST_ADDR == HOST_DATA_ADDR;

  khm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_in_fifo (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .in_valid(host_wr_data),
    .in_ready(fifo_ready),
    .in_data({HOST_ADDR[HOST_ADDR_CD_BIT], HOST_WDATA}),
    .out_valid(fifo_valid),
    .out_ready(in_load),
    .out_data(fifo_data)
  );

  // next byte enters only once the controller has taken the last one
  assign in_load = fifo_valid && (!in_full_r || CTL_DATA_RD);

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      HOST_WR_READY <= 1'b0;
    end else begin
      HOST_WR_READY <= fifo_ready;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      HOST_RDATA <= '0;
      HOST_RACK <= 1'b0;
    end else begin
      HOST_RACK <= HOST_RD && (HOST_ADDR == HOST_DATA_ADDR || HOST_ADDR == HOST_CMD_ADDR || host_fr_hit); // RQ25
      if (HOST_ADDR == HOST_DATA_ADDR) begin
        HOST_RDATA <= out_buf_r;
      end else if (HOST_ADDR == HOST_CMD_ADDR) begin
        HOST_RDATA <= CTL_STATUS;
      end else begin
        HOST_RDATA <= fr_r;
      end
    end
  end

  // mailbox buffers and flags; a set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (CTL_DATA_WR) begin
      out_buf_r <= CTL_WDATA; // RQ11
    end
    if (in_load) begin
      in_buf_r <= fifo_data[7:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      out_full_r <= 1'b0;
      in_full_r <= 1'b0;
      cd_r <= 1'b0;
      user_bits_r <= STATUS_RST;
    end else begin
      if (CTL_DATA_WR) begin
        out_full_r <= 1'b1; // RQ11 RQ17
      end else if (host_out_rd) begin
        out_full_r <= 1'b0; // RQ17
      end
      if (in_load) begin
        in_full_r <= 1'b1; // RQ16
        cd_r <= fifo_data[8]; // RQ15
      end else if (CTL_DATA_RD) begin
        in_full_r <= 1'b0; // RQ12 RQ16
      end
      if (CTL_STATUS_WR) begin
        user_bits_r <= CTL_WDATA & STATUS_USER_MASK; // RQ14
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      CTL_STATUS <= STATUS_RST; // RQ20
      CTL_DATA_RDATA <= '0;
      KEYBOARD_INTERRUPT_OUT <= 1'b0;
      CTL_INT_IN_FULL <= 1'b0;
      CTL_INT_TMR <= 1'b0;
    end else begin
      CTL_STATUS <= user_bits_r; // RQ13
      CTL_STATUS[ST_OUT_FULL_BIT] <= out_full_r; // RQ13
      CTL_STATUS[ST_IN_FULL_BIT] <= in_full_r; // RQ13
      CTL_STATUS[ST_CD_BIT] <= cd_r; // RQ13
      CTL_DATA_RDATA <= in_buf_r; // RQ12
      KEYBOARD_INTERRUPT_OUT <= out_full_r && CTL_KBD_INT_EN; // RQ11
      CTL_INT_IN_FULL <= in_full_r && CTL_IN_FULL_INT_EN; // RQ9 RQ16
      CTL_INT_TMR <= tmr_flag_r && CTL_TMR_INT_EN; // RQ9
    end
  end

  // timer keeps counting in soft power-down, only hard power-down stops it
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      tmr_r <= '0;
      tmr_flag_r <= 1'b0;
    end else begin
      if (core_tick && CTL_TMR_RUN && pwr_r != KHM_HARD_PD) begin
        tmr_r <= tmr_r + 8'h01; // RQ3
      end
      if (core_tick && CTL_TMR_RUN && pwr_r != KHM_HARD_PD && tmr_r == 8'hff) begin
        tmr_flag_r <= 1'b1; // RQ9
      end else if (CTL_TMR_ACK) begin
        tmr_flag_r <= 1'b0;
      end
    end
  end

  // power-down control; a host byte reaching the input buffer is the wake
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      pwr_r <= KHM_RUN; // RQ6
      CTL_WAKE_CALL <= 1'b0;
      CTL_WAKE_NEXT <= 1'b0;
    end else begin
      CTL_WAKE_CALL <= 1'b0;
      CTL_WAKE_NEXT <= 1'b0;
      case (pwr_r)
        KHM_RUN: begin
          if (CTL_STOP) begin
            pwr_r <= KHM_HARD_PD; // RQ7
          end else if (CTL_HALT) begin
            pwr_r <= KHM_SOFT_PD; // RQ4
          end
        end
        KHM_SOFT_PD, KHM_HARD_PD: begin
          if (in_load) begin
            pwr_r <= KHM_RUN; // RQ4 RQ7
            CTL_WAKE_CALL <= CTL_IN_FULL_INT_EN; // RQ5
            CTL_WAKE_NEXT <= !CTL_IN_FULL_INT_EN; // RQ5
          end
        end
        default: begin
          pwr_r <= KHM_RUN;
        end
      endcase
    end
  end

  // reset from either power-down mode restarts at address zero
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      CTL_FETCH_ZERO <= 1'b1; // RQ6
      CORE_CLK_EN <= 1'b0;
      ALU_CLK_EN <= 1'b0;
      OSC_DRV_EN <= 1'b1;
    end else begin
      CTL_FETCH_ZERO <= 1'b0;
      CORE_CLK_EN <= core_tick && pwr_r != KHM_HARD_PD; // RQ3 RQ7
      ALU_CLK_EN <= core_tick && pwr_r == KHM_RUN; // RQ3
      OSC_DRV_EN <= pwr_r != KHM_HARD_PD; // RQ7
    end
  end

  // program and data memory; program store filled through the load port
  always_ff @(posedge SYS_CLK) begin
    if (PGM_LOAD_WE) begin
      rom[PGM_LOAD_ADDR] <= PGM_LOAD_DATA; // RQ10
    end
    CTL_OPCODE <= rom[CTL_PC]; // RQ10
  end

  always_ff @(posedge SYS_CLK) begin
    if (CTL_RAM_WE) begin
      ram[CTL_RAM_ADDR] <= CTL_WDATA; // RQ10
    end
    CTL_RAM_RDATA <= ram[CTL_RAM_ADDR]; // RQ10
  end

  // port 2 latch; its reset value pulls every pin low
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      p2_r <= PORT2_RST; // RQ20
      CTL_PORT2 <= PORT2_RST;
    end else begin
      if (CTL_PORT2_WR) begin
        p2_r <= CTL_WDATA;
      end
      CTL_PORT2 <= CTL_PORT2_WR ? CTL_WDATA : p2_r;
    end
  end

  // open drain: the output level is always low, only the enable moves
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      KBD_CLOCK_PIN_OE <= 1'b1; // RQ20
      KBD_DATA_PIN_OE <= 1'b1; // RQ20
      MOUSE_CLOCK_PIN_OE <= 1'b1; // RQ20
      MOUSE_DATA_PIN_OE <= 1'b1; // RQ20
    end else begin
      KBD_CLOCK_PIN_OE <= p2_r[P2_KBD_CLOCK_BIT]; // RQ1
      KBD_DATA_PIN_OE <= p2_r[P2_KBD_DATA_BIT]; // RQ1
      MOUSE_CLOCK_PIN_OE <= p2_r[P2_MCLK_BIT]; // RQ2
      MOUSE_DATA_PIN_OE <= p2_r[P2_MOUSE_DATA_BIT]; // RQ2
    end
  end

  always_ff @(posedge SYS_CLK) begin
    KBD_CLOCK_PIN_O <= 1'b0;
    KBD_DATA_PIN_O <= 1'b0;
    MOUSE_CLOCK_PIN_O <= 1'b0;
    MOUSE_DATA_PIN_O <= 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      TEST_INPUT_ZERO <= 1'b0;
      TEST_INPUT_ONE <= 1'b0;
      PORT1_BIT0 <= 1'b0;
      PORT1_BIT1 <= 1'b0;
    end else begin
      TEST_INPUT_ZERO <= KBD_CLOCK_PIN_I; // RQ1
      PORT1_BIT0 <= KBD_DATA_PIN_I; // RQ1
      TEST_INPUT_ONE <= MOUSE_CLOCK_PIN_I; // RQ2
      PORT1_BIT1 <= MOUSE_DATA_PIN_I; // RQ2
    end
  end

  // fast-reset port: only bits 1..0 are stored, the rest read fixed
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      fr_r <= FAST_RESET_RST; // RQ22
    end else if (host_fr_wr) begin
      fr_r <= (FAST_RESET_RST & ~FAST_RESET_WMASK) | (HOST_WDATA & FAST_RESET_WMASK); // RQ22 RQ21
    end
  end

  // pulse re-arms only after bit 0 has gone back to zero
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      alt_cnt_r <= '0;
      alt_armed_r <= 1'b1;
      alt_pulse_r <= 1'b0;
      ALTERNATE_CPU_RESET_N <= 1'b1;
      ALTERNATE_GATE_A20 <= 1'b0;
    end else begin
      ALTERNATE_GATE_A20 <= fr_r[FR_A20_BIT]; // RQ23
      ALTERNATE_CPU_RESET_N <= !alt_pulse_r; // RQ24
      if (!fr_r[FR_RST_BIT]) begin
        alt_armed_r <= 1'b1; // RQ24
      end
      if (alt_cnt_r != '0) begin
        alt_cnt_r <= alt_cnt_r - 5'd1;
        if (alt_cnt_r == 5'(ALT_PULSE_CYC + 1)) begin
          alt_pulse_r <= 1'b1; // RQ24
        end
        if (alt_cnt_r == 5'd1) begin
          alt_pulse_r <= 1'b0;
        end
      end else if (fr_r[FR_RST_BIT] && alt_armed_r) begin
        alt_armed_r <= 1'b0; // RQ24
        alt_cnt_r <= 5'(ALT_DELAY_CYC + ALT_PULSE_CYC); // RQ24
      end
    end
  end

  a_out_full_set: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ17
    CTL_DATA_WR |=> ##1 CTL_STATUS[ST_OUT_FULL_BIT])
    else $error("output-full not set after controller write");
  a_out_full_clear: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ17
    host_out_rd && !CTL_DATA_WR |=> !out_full_r)
    else $error("output-full not cleared by host read");
  a_in_full_clear: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ16
    CTL_DATA_RD && !fifo_valid |=> ##1 !CTL_INT_IN_FULL && !CTL_STATUS[ST_IN_FULL_BIT])
    else $error("input-full or interrupt not cleared by controller read");
  a_cd_from_addr: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ15
    in_load |=> cd_r == $past(fifo_data[8]))
    else $error("command flag does not follow host address bit");
  a_kbd_pin_invert: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ1
    $past(RESETN) |-> ##1 KBD_CLOCK_PIN_OE == $past(p2_r[P2_KBD_CLOCK_BIT]) && !KBD_CLOCK_PIN_O)
    else $error("keyboard clock pin not the inverse of port2 bit6");
  a_mouse_pin_invert: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ2
    ##1 MOUSE_DATA_PIN_OE == $past(p2_r[P2_MOUSE_DATA_BIT]))
    else $error("mouse data pin not the inverse of port2 bit2");
  a_soft_pd_alu: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ3
    pwr_r == KHM_SOFT_PD |=> !ALU_CLK_EN && OSC_DRV_EN)
    else $error("alu clock running in soft power-down");
  a_hard_pd_osc: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ7
    pwr_r == KHM_RUN && CTL_STOP |=> ##1 !OSC_DRV_EN && !CORE_CLK_EN)
    else $error("oscillator still enabled in hard power-down");
  a_wake_call: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ4 RQ5
    pwr_r != KHM_RUN && in_load && CTL_IN_FULL_INT_EN |=> CTL_WAKE_CALL && !CTL_WAKE_NEXT && pwr_r == KHM_RUN)
    else $error("host write wake did not call interrupt routine");
  a_fr_gated: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ21 RQ25
    HOST_WR && HOST_ADDR == FAST_RESET_ADDR && !FAST_RESET_GATE_CONFIG |=> $stable(fr_r))
    else $error("fast-reset port written while disabled");
  // counter load to pin low is eleven edges: delay stage plus one register stage
  a_alt_delay: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RQ24
    $rose(alt_cnt_r != '0) |->
      ALTERNATE_CPU_RESET_N [*8] ##1 ALTERNATE_CPU_RESET_N [*3] ##1 !ALTERNATE_CPU_RESET_N)
    else $error("alternate reset pulse not after the delay");
endmodule

// ---- verif/khm_host_model.sv ----
// host processor model: one-cycle read and write strobes on the host port
`timescale 1ns/10ps

module khm_host_model (
  input wire logic SYS_CLK,
  output logic HOST_WR,
  output logic HOST_RD,
  output logic [7:0] HOST_ADDR,
  output logic [7:0] HOST_WDATA,
  input wire logic HOST_RACK,
  input wire logic [7:0] HOST_RDATA
);
  initial begin
    HOST_WR = 1'b0;
    HOST_RD = 1'b0;
    HOST_ADDR = 8'h00;
    HOST_WDATA = 8'h00;
  end

  // released bus shows the inverse, so a stale copy can never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    #1;
    HOST_ADDR = a;
    HOST_WDATA = d;
    HOST_WR = 1'b1;
    @(posedge SYS_CLK);
    #1;
    HOST_WR = 1'b0;
    HOST_ADDR = ~a;
    HOST_WDATA = ~d;
  endtask

  // acknowledge stands one cycle only, so it is taken right after the read edge
  task automatic rd(input logic [7:0] a, output logic ack, output logic [7:0] q);
    @(posedge SYS_CLK);
    #1;
    HOST_ADDR = a;
    HOST_RD = 1'b1;
    @(posedge SYS_CLK);
    #1;
    ack = HOST_RACK;
    q = HOST_RDATA;
    HOST_RD = 1'b0;
    HOST_ADDR = ~a;
  endtask
endmodule

// ---- verif/test_khm_top.sv ----
// self-checking bench for the keyboard host mailbox block
`timescale 1ns/10ps

`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("MISMATCH at %0t: line %0d got %0h want %0h", $time, `__LINE__, a, b); \
  end \
end

module test_khm_top;
  import khm_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic FAST_RESET_GATE_CONFIG = 1'b0;
  logic CTL_DATA_WR, CTL_DATA_RD, CTL_STATUS_WR, CTL_PORT2_WR, CTL_HALT, CTL_STOP, CTL_TMR_ACK;
  logic CTL_RAM_WE, PGM_LOAD_WE, CTL_KBD_INT_EN, CTL_IN_FULL_INT_EN, CTL_TMR_INT_EN, CTL_TMR_RUN;
  logic [7:0] CTL_WDATA, PGM_LOAD_DATA, CTL_RAM_ADDR;
  logic [10:0] CTL_PC, PGM_LOAD_ADDR;
  logic HOST_WR, HOST_RD, HOST_WR_READY, HOST_RACK, ALTERNATE_CPU_RESET_N, ALTERNATE_GATE_A20;
  logic [7:0] HOST_ADDR, HOST_WDATA, HOST_RDATA, CTL_DATA_RDATA, CTL_STATUS, CTL_OPCODE, CTL_RAM_RDATA, CTL_PORT2;
  logic KEYBOARD_INTERRUPT_OUT, CTL_INT_IN_FULL, CTL_INT_TMR, CORE_CLK_EN, ALU_CLK_EN, OSC_DRV_EN;
  logic CTL_WAKE_CALL, CTL_WAKE_NEXT, CTL_FETCH_ZERO, PORT1_BIT0, PORT1_BIT1, TEST_INPUT_ZERO, TEST_INPUT_ONE;
  logic KBD_CLOCK_PIN_I, KBD_CLOCK_PIN_O, KBD_CLOCK_PIN_OE, KBD_DATA_PIN_I, KBD_DATA_PIN_O, KBD_DATA_PIN_OE;
  logic MOUSE_CLOCK_PIN_I, MOUSE_CLOCK_PIN_O, MOUSE_CLOCK_PIN_OE;
  logic MOUSE_DATA_PIN_I, MOUSE_DATA_PIN_O, MOUSE_DATA_PIN_OE;
  int mismatches = 0;
  int check_count = 0;
  int n, dl, lo, a, c;
  logic ack, cl, nx;
  logic [7:0] q;
  logic [2:0] pb [4] = '{3'd6, 3'd7, 3'd3, 3'd2};

  // pull-ups hold each line high once nobody drives it low
  assign KBD_CLOCK_PIN_I = KBD_CLOCK_PIN_OE ? KBD_CLOCK_PIN_O : 1'b1;
  assign KBD_DATA_PIN_I = KBD_DATA_PIN_OE ? KBD_DATA_PIN_O : 1'b1;
  assign MOUSE_CLOCK_PIN_I = MOUSE_CLOCK_PIN_OE ? MOUSE_CLOCK_PIN_O : 1'b1;
  assign MOUSE_DATA_PIN_I = MOUSE_DATA_PIN_OE ? MOUSE_DATA_PIN_O : 1'b1;

  khm_top i_dut (.*);
  khm_host_model i_host (.*);

  always #25 SYS_CLK = ~SYS_CLK;

  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge SYS_CLK);
      #1;
    end
  endtask

  // k: 0 data wr, 1 data rd, 2 status wr, 3 port2 wr, 4 halt, 5 stop, 6 timer ack, 7 ram wr, 8 program load
  task automatic ctl(input int k, input logic [7:0] d);
    tick(1);
    CTL_WDATA = d;
    {PGM_LOAD_WE, CTL_RAM_WE, CTL_TMR_ACK, CTL_STOP, CTL_HALT, CTL_PORT2_WR, CTL_STATUS_WR, CTL_DATA_RD,
      CTL_DATA_WR} = 9'h001 << k;
    tick(1);
    {PGM_LOAD_WE, CTL_RAM_WE, CTL_TMR_ACK, CTL_STOP, CTL_HALT, CTL_PORT2_WR, CTL_STATUS_WR, CTL_DATA_RD,
      CTL_DATA_WR} = 9'h000;
  endtask

  // 80 means no pulse seen in the window
  task automatic fr(input logic [7:0] d);
    i_host.wr(FAST_RESET_ADDR, d);
    dl = 0;
    while (ALTERNATE_CPU_RESET_N === 1'b1 && dl < 80) begin
      tick(1);
      dl++;
    end
    lo = 0;
    while (ALTERNATE_CPU_RESET_N !== 1'b1 && lo < 80) begin
      tick(1);
      lo++;
    end
  endtask

  task automatic count_en();
    a = 0;
    c = 0;
    repeat (10) begin
      tick(1);
      a += (ALU_CLK_EN === 1'b1);
      c += (CORE_CLK_EN === 1'b1);
    end
  endtask

  task automatic wake(input logic [7:0] d);
    cl = 1'b0;
    nx = 1'b0;
    i_host.wr(HOST_DATA_ADDR, d);
    repeat (6) begin
      tick(1);
      cl = cl | CTL_WAKE_CALL;
      nx = nx | CTL_WAKE_NEXT;
    end
  endtask

  initial begin
    repeat (100000) @(posedge SYS_CLK);
    mismatches++;
    finish_test();
  end

  initial begin
    {PGM_LOAD_WE, CTL_RAM_WE, CTL_TMR_ACK, CTL_STOP, CTL_HALT, CTL_PORT2_WR, CTL_STATUS_WR, CTL_DATA_RD,
      CTL_DATA_WR} = 9'h000;
    {CTL_KBD_INT_EN, CTL_IN_FULL_INT_EN, CTL_TMR_INT_EN, CTL_TMR_RUN} = 4'he;
    CTL_WDATA = 8'h00;
    PGM_LOAD_DATA = 8'h00;
    CTL_RAM_ADDR = 8'h00;
    CTL_PC = 11'h000;
    PGM_LOAD_ADDR = 11'h000;
    tick(16);
    `CHK(CTL_STATUS, STATUS_RST)
    `CHK({KBD_CLOCK_PIN_OE, KBD_DATA_PIN_OE, MOUSE_CLOCK_PIN_OE, MOUSE_DATA_PIN_OE}, 4'hf)
    `CHK({ALTERNATE_CPU_RESET_N, ALTERNATE_GATE_A20, CTL_FETCH_ZERO}, 3'b101)
    RESETN = 1'b1;
    tick(2);
    `CHK(CTL_FETCH_ZERO, 1'b0)
    for (int i = 0; i < 4; i++) begin
      ctl(3, 8'h01 << pb[i]);
      tick(3);
      `CHK({KBD_CLOCK_PIN_OE, KBD_DATA_PIN_OE, MOUSE_CLOCK_PIN_OE, MOUSE_DATA_PIN_OE}, 4'h8 >> i)
      `CHK(CTL_PORT2, 8'h01 << pb[i])
      `CHK({TEST_INPUT_ZERO, PORT1_BIT0, TEST_INPUT_ONE, PORT1_BIT1}, ~(4'h8 >> i))
    end
    i_host.wr(HOST_CMD_ADDR, 8'ha5);
    tick(3);
    `CHK(CTL_STATUS & 8'h0b, 8'h0a)
    `CHK({CTL_INT_IN_FULL, CTL_DATA_RDATA}, 9'h1a5)
    ctl(1, 8'h00);
    tick(3);
    `CHK({CTL_INT_IN_FULL, CTL_STATUS[1]}, 2'b00)
    i_host.wr(HOST_DATA_ADDR, 8'h5a);
    tick(3);
    `CHK(CTL_STATUS & 8'h0b, 8'h02)
    ctl(1, 8'h00);
    ctl(0, 8'h3c);
    tick(2);
    `CHK({KEYBOARD_INTERRUPT_OUT, CTL_STATUS[0]}, 2'b11)
    CTL_KBD_INT_EN = 1'b0;
    tick(2);
    `CHK({KEYBOARD_INTERRUPT_OUT, CTL_STATUS[0]}, 2'b01)
    CTL_KBD_INT_EN = 1'b1;
    i_host.rd(HOST_DATA_ADDR, ack, q);
    `CHK({ack, q}, 9'h13c)
    tick(2);
    `CHK({KEYBOARD_INTERRUPT_OUT, CTL_STATUS[0]}, 2'b00)
    ctl(2, 8'hff);
    tick(3);
    `CHK(CTL_STATUS, STATUS_USER_MASK)
    i_host.rd(HOST_CMD_ADDR, ack, q);
    `CHK({ack, q}, {1'b1, STATUS_USER_MASK})
    ctl(2, 8'h00);
    i_host.rd(8'h70, ack, q);
    `CHK(ack, 1'b0)
    // input buffer plus an 8-deep queue: the ninth byte fills it
    n = 0;
    while (HOST_WR_READY === 1'b1 && n < 20) begin
      i_host.wr(HOST_DATA_ADDR, 8'(n + 1));
      tick(1);
      n++;
    end
    `CHK(n, 9)
    i_host.wr(HOST_DATA_ADDR, 8'hee);
    for (int i = 1; i <= 9; i++) begin
      `CHK(CTL_DATA_RDATA, 8'(i))
      ctl(1, 8'h00);
      tick(3);
    end
    `CHK({HOST_WR_READY, CTL_STATUS[1]}, 2'b10)
    i_host.rd(FAST_RESET_ADDR, ack, q);
    `CHK(ack, 1'b0)
    fr(8'h02);
    `CHK(ALTERNATE_GATE_A20, 1'b0)
    FAST_RESET_GATE_CONFIG = 1'b1;
    i_host.rd(FAST_RESET_ADDR, ack, q);
    `CHK({ack, q}, {1'b1, FAST_RESET_RST})
    fr(8'h02);
    `CHK(ALTERNATE_GATE_A20, 1'b1)
    fr(8'h03);
    `CHK(dl >= 10 && dl < 80 && lo >= 20 && lo < 80, 1'b1)
    fr(8'h03);
    `CHK(dl, 80)
    fr(8'h02);
    fr(8'h03);
    `CHK(dl < 80, 1'b1)
    i_host.rd(FAST_RESET_ADDR, ack, q);
    `CHK(q, FAST_RESET_RST | 8'h03)
    fr(8'h00);
    `CHK(ALTERNATE_GATE_A20, 1'b0)
    PGM_LOAD_ADDR = 11'h7ff;
    PGM_LOAD_DATA = 8'h5e;
    CTL_RAM_ADDR = 8'hff;
    ctl(8, 8'h00);
    ctl(7, 8'h9a);
    CTL_PC = 11'h7ff;
    tick(2);
    `CHK({CTL_OPCODE, CTL_RAM_RDATA}, 16'h5e9a)
    ctl(4, 8'h00);
    tick(3);
    count_en();
    `CHK({a == 0, c == 6}, 2'b11)
    CTL_TMR_RUN = 1'b1;
    n = 0;
    while (CTL_INT_TMR !== 1'b1 && n < 20000) begin
      tick(1);
      n++;
    end
    if (n == 20000) begin
      mismatches++;
      finish_test();
    end
    ctl(6, 8'h00);
    CTL_TMR_RUN = 1'b0;
    tick(3);
    `CHK(CTL_INT_TMR, 1'b0)
    wake(8'h77);
    `CHK({cl, nx}, 2'b10)
    count_en();
    `CHK(a, 6)
    ctl(1, 8'h00);
    CTL_IN_FULL_INT_EN = 1'b0;
    ctl(5, 8'h00);
    tick(1);
    count_en();
    `CHK({OSC_DRV_EN, c == 0}, 2'b01)
    wake(8'h78);
    `CHK({cl, nx, OSC_DRV_EN}, 3'b011)
    ctl(1, 8'h00);
    ctl(5, 8'h00);
    tick(3);
    RESETN = 1'b0;
    tick(32);
    `CHK({CTL_FETCH_ZERO, OSC_DRV_EN, CTL_STATUS}, 10'h300)
    RESETN = 1'b1;
    tick(2);
    `CHK(CTL_FETCH_ZERO, 1'b0)
    finish_test();
  end
endmodule
